// ### src/dfr_ramp.sv
`timescale 1ns/10ps

// Behaviour
// - with a nonzero floor, the output climbs from standstill to the floor frequency within one second.
// - above the floor the output ramps to the maximum over the start-up ramp time, eight seconds by default.
// - the floor frequency setting resets to thirty hertz.
// - with the floor at zero the ramp is one linear segment from standstill to the maximum over the start-up ramp time.
// - ramp times cover the span between the floor and the maximum, up for start and down for stop.
// - without the keypad the maximum is sixty hertz and both ramp times are fixed.
// - without the keypad switch 7 picks the floor: off gives zero hertz, on gives thirty hertz.
// - while decelerating above the floor, sensed regeneration holds the frequency so the shutdown lengthens.
// - analog speed commands apply only with the keypad fitted and the profile setting equal to one.
// - a two-position switch picks the voltage or the current-loop analog source.
// - the analog target is the maximum times the input over its full scale.
// - the analog target never falls below the floor frequency.
// - analog speed control acts only in automatic mode.
// - on stop with a nonzero floor, the output falls from the floor to standstill within one second.
// - the floor accepts zero to one hundred twenty hertz, and zero disables it.
module dfr_ramp #(
    parameter int unsigned TICK_CYCLES = dfr_pkg::TICK_CYCLES
) (
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    input  wire logic [7:0]                 s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [7:0]                 s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    input  wire logic                       run_request,
    input  wire logic                       keypad_fitted,
    input  wire logic                       floor_switch_on,
    input  wire logic                       analog_src_current,
    input  wire logic                       regen_detect,
    input  wire logic [dfr_pkg::ADC_W-1:0]  analog_volt_code,
    input  wire logic [dfr_pkg::ADC_W-1:0]  analog_curr_code,
    output logic [dfr_pkg::FREQ_W-1:0]      freq_setpoint,
    output logic                            running,
    output logic                            regen_extend
);
    localparam int unsigned FW = dfr_pkg::FREQ_W;
    localparam int unsigned DW = dfr_pkg::DIV_W;
    localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [dfr_pkg::SYNC_N-1:0] pin_raw, pin_s1_q, pin_s2_q, pin_s3_q, pin_q;
    logic                       run_req, keypad, sw_floor, src_curr, regen;

    assign pin_raw = {regen_detect, analog_src_current, floor_switch_on, keypad_fitted, run_request};
    assign {regen, src_curr, sw_floor, keypad, run_req} = pin_q;

    // a level counts only once stages two and three agree, which rejects a one-cycle glitch
    for (genvar i = 0; i < dfr_pkg::SYNC_N; i++) begin : g_sync
        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                {pin_s1_q[i], pin_s2_q[i], pin_s3_q[i], pin_q[i]} <= 4'h0;
            end else begin
                {pin_s1_q[i], pin_s2_q[i], pin_s3_q[i]} <= {pin_raw[i], pin_s1_q[i], pin_s2_q[i]};
                if (pin_s2_q[i] == pin_s3_q[i]) pin_q[i] <= pin_s3_q[i];
            end
        end
    end

    // ****************************************
    // register bus
    // ****************************************
    logic [7:0]  floor_q, maxf_q, up_s_q, dn_s_q, profile_q, aw_addr_q;
    logic [31:0] w_data_q, rd_word;
    logic [5:0]  status_word;
    logic        hand_q, aw_hold_q, w_hold_q, w_lane0_q, do_write, rd_hit;

    assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write      = aw_hold_q && w_hold_q && !s_axi_bvalid;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= '0;
            w_lane0_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (do_write) begin
                aw_hold_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q  <= 1'b1;
                w_data_q  <= s_axi_wdata;
                w_lane0_q <= s_axi_wstrb[0];
            end else if (do_write) begin
                w_hold_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= dfr_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_q <= dfr_pkg::REG_PROFILE) ? dfr_pkg::RESP_OKAY : dfr_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hand_q    <= dfr_pkg::CTRL_HAND_RESET;
            floor_q   <= dfr_pkg::FLOOR_DEFAULT_HZ;
            maxf_q    <= dfr_pkg::MAXF_DEFAULT_HZ;
            up_s_q    <= dfr_pkg::RAMP_DEFAULT_S;
            dn_s_q    <= dfr_pkg::RAMP_DEFAULT_S;
            profile_q <= dfr_pkg::PROFILE_DEFAULT;
        end else if (do_write && w_lane0_q) begin
            if (aw_addr_q == dfr_pkg::REG_CTRL) hand_q <= w_data_q[dfr_pkg::CTRL_HAND_BIT];
            else if (aw_addr_q == dfr_pkg::REG_FLOOR) begin
                // out-of-range settings saturate at the top of the range
                floor_q <= (w_data_q[7:0] > dfr_pkg::FLOOR_LIMIT_HZ) ? dfr_pkg::FLOOR_LIMIT_HZ : w_data_q[7:0];
            end else if (aw_addr_q == dfr_pkg::REG_MAXF) maxf_q <= w_data_q[7:0];
            else if (aw_addr_q == dfr_pkg::REG_RAMP_UP) up_s_q <= (w_data_q[7:0] == 8'h00) ? 8'h01 : w_data_q[7:0];
            else if (aw_addr_q == dfr_pkg::REG_RAMP_DN) dn_s_q <= (w_data_q[7:0] == 8'h00) ? 8'h01 : w_data_q[7:0];
            else if (aw_addr_q == dfr_pkg::REG_PROFILE) profile_q <= w_data_q[7:0];
        end
    end

    always_comb begin
        rd_word = '0;
        rd_hit  = 1'b1;
        if (s_axi_araddr == dfr_pkg::REG_CTRL) rd_word[dfr_pkg::CTRL_HAND_BIT] = hand_q;
        else if (s_axi_araddr == dfr_pkg::REG_FLOOR) rd_word[7:0] = floor_q;
        else if (s_axi_araddr == dfr_pkg::REG_MAXF) rd_word[7:0] = maxf_q;
        else if (s_axi_araddr == dfr_pkg::REG_RAMP_UP) rd_word[7:0] = up_s_q;
        else if (s_axi_araddr == dfr_pkg::REG_RAMP_DN) rd_word[7:0] = dn_s_q;
        else if (s_axi_araddr == dfr_pkg::REG_PROFILE) rd_word[7:0] = profile_q;
        else if (s_axi_araddr == dfr_pkg::REG_FREQ) rd_word[FW-1:0] = freq_setpoint;
        else if (s_axi_araddr == dfr_pkg::REG_STATUS) rd_word[5:0] = status_word;
        else rd_hit = 1'b0;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= dfr_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? dfr_pkg::RESP_OKAY : dfr_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************
    // effective settings
    // ****************************************
    dfr_pkg::dfr_cfg_s cfg;
    logic [FW-1:0]     floor_fx;
    logic [FW-1:0]     max_fx;

    always_comb begin
        if (keypad) begin
            cfg = '{floor_hz: floor_q, max_hz: maxf_q, up_s: up_s_q, dn_s: dn_s_q};
        end else begin
            cfg.floor_hz = sw_floor ? dfr_pkg::FLOOR_SW_ON_HZ : dfr_pkg::FLOOR_SW_OFF_HZ;
            cfg.max_hz   = dfr_pkg::MAXF_BASIC_HZ;
            cfg.up_s     = dfr_pkg::RAMP_DEFAULT_S;
            cfg.dn_s     = dfr_pkg::RAMP_DEFAULT_S;
        end
    end

    assign floor_fx = {cfg.floor_hz, {dfr_pkg::FRAC_BITS{1'b0}}};
    assign max_fx   = {cfg.max_hz, {dfr_pkg::FRAC_BITS{1'b0}}};

    // ****************************************
    // increments, recomputed round-robin
    // ****************************************
    dfr_pkg::dfr_job_e job_q;
    logic [DW-1:0]     span, dur_ms, div_quo;
    logic              div_busy, div_done, div_start_q;
    logic [FW-1:0]     inc_fast_q, inc_up_q, inc_dn_q, inc_new;

    always_comb begin
        span   = '0;
        dur_ms = DW'(dfr_pkg::FAST_SEG_MS);
        case (job_q)
            dfr_pkg::JOB_FAST: span = DW'(floor_fx);
            dfr_pkg::JOB_UP: begin
                span   = (max_fx > floor_fx) ? DW'(max_fx - floor_fx) : '0;
                dur_ms = DW'(cfg.up_s) * DW'(dfr_pkg::MS_PER_S);
            end
            default: begin
                span   = (max_fx > floor_fx) ? DW'(max_fx - floor_fx) : '0;
                dur_ms = DW'(cfg.dn_s) * DW'(dfr_pkg::MS_PER_S);
            end
        endcase
    end

    // rounding up keeps every segment at or under its stated duration
    dfr_div #(
        .W(DW)
    ) u_div (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .start    (div_start_q),
        .dividend (span + dur_ms - DW'(1)),
        .divisor  (dur_ms),
        .busy     (div_busy),
        .done     (div_done),
        .quotient (div_quo)
    );

    assign inc_new = (div_quo[FW-1:0] == '0) ? FW'(1) : div_quo[FW-1:0];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            job_q       <= dfr_pkg::JOB_FAST;
            div_start_q <= 1'b0;
            inc_fast_q  <= FW'(1);
            inc_up_q    <= FW'(1);
            inc_dn_q    <= FW'(1);
        end else begin
            div_start_q <= !div_busy && !div_start_q && !div_done;
            if (div_done) begin
                case (job_q)
                    dfr_pkg::JOB_FAST: begin
                        inc_fast_q <= inc_new;
                        job_q      <= dfr_pkg::JOB_UP;
                    end
                    dfr_pkg::JOB_UP: begin
                        inc_up_q <= inc_new;
                        job_q    <= dfr_pkg::JOB_DN;
                    end
                    default: begin
                        inc_dn_q <= inc_new;
                        job_q    <= dfr_pkg::JOB_FAST;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // target frequency
    // ****************************************
    logic [dfr_pkg::ADC_W-1:0] adc_code;
    logic [FW-1:0]             analog_fx, target;
    logic                      analog_on;

    assign adc_code  = src_curr ? analog_curr_code : analog_volt_code;
    // full scale is 2^ADC_W codes, so the ratio becomes a shift
    // the product is widened first, a 24-bit product would overflow above a sixteenth of a hertz
    assign analog_fx = FW'((FW + dfr_pkg::ADC_W)'(max_fx) * (FW + dfr_pkg::ADC_W)'(adc_code) >> dfr_pkg::ADC_W);
    assign analog_on = keypad && (profile_q == dfr_pkg::PROFILE_ANALOG) && !hand_q;

    // ****************************************
    // ramp accumulator
    // ****************************************
    dfr_pkg::dfr_ramp_e state_q;
    logic [TW-1:0]      tick_cnt_q;
    logic [FW-1:0]      freq_q, freq_d, lim;
    logic [FW:0]        step_up;
    logic               tick, hold;

    always_comb begin
        if (state_q != dfr_pkg::RAMP_RUNNING) begin
            target = '0;
        end else if (analog_on) begin
            target = (analog_fx < floor_fx) ? floor_fx : analog_fx;
        end else begin
            target = max_fx;
        end
    end

    assign tick = (tick_cnt_q == TW'(TICK_CYCLES - 1));

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) tick_cnt_q <= '0;
        else tick_cnt_q <= tick ? '0 : tick_cnt_q + TW'(1);
    end

    // only the slow segment above the floor stretches, the fast segment keeps its one-second bound
    assign hold = regen && (freq_q > floor_fx) && (freq_q > target);

    always_comb begin
        freq_d  = freq_q;
        step_up = '0;
        lim     = target;
        if (freq_q < target) begin
            if (freq_q < floor_fx) begin
                lim     = (target < floor_fx) ? target : floor_fx;
                step_up = {1'b0, freq_q} + {1'b0, inc_fast_q};
            end else begin
                step_up = {1'b0, freq_q} + {1'b0, inc_up_q};
            end
            freq_d = (step_up >= {1'b0, lim}) ? lim : step_up[FW-1:0];
        end else if (freq_q > target && !hold) begin
            if (freq_q > floor_fx) begin
                lim = (target > floor_fx) ? target : floor_fx;
                freq_d = (freq_q - lim <= inc_dn_q) ? lim : freq_q - inc_dn_q;
            end else begin
                freq_d = (freq_q - target <= inc_fast_q) ? target : freq_q - inc_fast_q;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) freq_q <= '0;
        else if (tick) freq_q <= freq_d;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= dfr_pkg::RAMP_STOPPED;
        end else begin
            case (state_q)
                dfr_pkg::RAMP_STOPPED: if (run_req) state_q <= dfr_pkg::RAMP_RUNNING;
                dfr_pkg::RAMP_RUNNING: if (!run_req) state_q <= dfr_pkg::RAMP_STOPPING;
                default: begin
                    if (run_req) state_q <= dfr_pkg::RAMP_RUNNING;
                    else if (freq_q == '0) state_q <= dfr_pkg::RAMP_STOPPED;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) regen_extend <= 1'b0;
        else regen_extend <= hold;
    end

    assign freq_setpoint = freq_q;
    assign running       = (state_q != dfr_pkg::RAMP_STOPPED);

    assign status_word[dfr_pkg::ST_RUNNING_BIT]  = state_q == dfr_pkg::RAMP_RUNNING;
    assign status_word[dfr_pkg::ST_STOPPING_BIT] = state_q == dfr_pkg::RAMP_STOPPING;
    assign status_word[dfr_pkg::ST_REGEN_BIT]    = regen_extend;
    assign status_word[dfr_pkg::ST_ANALOG_BIT]   = analog_on;
    assign status_word[dfr_pkg::ST_KEYPAD_BIT]   = keypad;
    assign status_word[dfr_pkg::ST_AT_TGT_BIT]   = freq_q == target;

endmodule

// ### shared/dfr_pkg.sv
package dfr_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned CLK_PERIOD_NS  = 20;
    localparam int unsigned TICK_PERIOD_NS = 1_000_000;
    localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned FAST_SEG_MS    = 1000;
    localparam int unsigned MS_PER_S       = 1000;

    // ****************************************
    // number formats
    // ****************************************
    localparam int unsigned FRAC_BITS = 16;
    localparam int unsigned FREQ_W    = 24;
    localparam int unsigned ADC_W     = 12;
    localparam int unsigned DIV_W     = 32;
    localparam int unsigned SYNC_N    = 5;

    // ****************************************
    // parameter defaults and limits
    // ****************************************
    localparam logic [7:0] FLOOR_DEFAULT_HZ = 8'h1E;
    localparam logic [7:0] FLOOR_LIMIT_HZ   = 8'h78;
    localparam logic [7:0] FLOOR_SW_ON_HZ   = 8'h1E;
    localparam logic [7:0] FLOOR_SW_OFF_HZ  = 8'h00;
    localparam logic [7:0] MAXF_DEFAULT_HZ  = 8'h3C;
    localparam logic [7:0] MAXF_BASIC_HZ    = 8'h3C;
    localparam logic [7:0] RAMP_DEFAULT_S   = 8'h08;
    localparam logic [7:0] PROFILE_DEFAULT  = 8'h00;
    localparam logic [7:0] PROFILE_ANALOG   = 8'h01;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_FLOOR   = 8'h04;
    localparam logic [7:0] REG_MAXF    = 8'h08;
    localparam logic [7:0] REG_RAMP_UP = 8'h0C;
    localparam logic [7:0] REG_RAMP_DN = 8'h10;
    localparam logic [7:0] REG_PROFILE = 8'h14;
    localparam logic [7:0] REG_FREQ    = 8'h18;
    localparam logic [7:0] REG_STATUS  = 8'h1C;

    localparam int unsigned CTRL_HAND_BIT   = 0;
    localparam logic        CTRL_HAND_RESET = 1'b0;

    localparam int unsigned ST_RUNNING_BIT = 0;
    localparam int unsigned ST_STOPPING_BIT = 1;
    localparam int unsigned ST_REGEN_BIT   = 2;
    localparam int unsigned ST_ANALOG_BIT  = 3;
    localparam int unsigned ST_KEYPAD_BIT  = 4;
    localparam int unsigned ST_AT_TGT_BIT  = 5;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic [7:0] floor_hz;
        logic [7:0] max_hz;
        logic [7:0] up_s;
        logic [7:0] dn_s;
    } dfr_cfg_s;

    typedef enum logic [1:0] {
        RAMP_STOPPED,
        RAMP_RUNNING,
        RAMP_STOPPING
    } dfr_ramp_e;

    typedef enum logic [1:0] {
        JOB_FAST,
        JOB_UP,
        JOB_DN
    } dfr_job_e;

endpackage

// ### src/dfr_div.sv
`timescale 1ns/10ps

// restoring divider, one quotient bit per clock
module dfr_div #(
    parameter int unsigned W = 32
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         start,
    input  wire logic [W-1:0] dividend,
    input  wire logic [W-1:0] divisor,
    output logic              busy,
    output logic              done,
    output logic [W-1:0]      quotient
);
    localparam int unsigned CW = $clog2(W + 1);

    logic [W-1:0]  rem_q;
    logic [W-1:0]  quo_q;
    logic [W-1:0]  dvs_q;
    logic [CW-1:0] cnt_q;
    logic [W:0]    trial;

    assign trial = {rem_q, quo_q[W-1]} - {1'b0, dvs_q};

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rem_q <= '0;
            quo_q <= '0;
            dvs_q <= '0;
            cnt_q <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                rem_q <= '0;
                quo_q <= dividend;
                dvs_q <= divisor;
                cnt_q <= CW'(W);
                busy  <= 1'b1;
            end else if (busy) begin
                if (trial[W]) begin
                    rem_q <= {rem_q[W-2:0], quo_q[W-1]};
                    quo_q <= {quo_q[W-2:0], 1'b0};
                end else begin
                    rem_q <= trial[W-1:0];
                    quo_q <= {quo_q[W-2:0], 1'b1};
                end
                cnt_q <= cnt_q - CW'(1);
                if (cnt_q == CW'(1)) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end

    assign quotient = quo_q;

endmodule

// ### tb/dfr_ramp_props.sv
`timescale 1ns/10ps
// ****************
// ramp and bus output checks
// ****************
module dfr_ramp_props (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [23:0] freq_setpoint,
    input wire logic        running,
    input wire logic        regen_extend
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_held;
        regen_extend ##1 regen_extend;
    endsequence
    a_regen_freeze: assert property (s_held |-> $stable(freq_setpoint)) else $error("moved in regen hold");
    a_regen_run: assert property (regen_extend |-> running) else $error("regen hold while stopped");
    a_stop_zero: assert property (!running |-> freq_setpoint == 24'h0) else $error("stopped above zero");
    // widest legal step: 255 Hz over one second of ticks
    a_step_size: assert property ($changed(freq_setpoint) |-> (freq_setpoint - $past(freq_setpoint) <= 24'h4150)
        || ($past(freq_setpoint) - freq_setpoint <= 24'h4150)) else $error("step too large");
    a_b_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
    a_r_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
    a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
    a_r_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
endmodule
bind dfr_ramp dfr_ramp_props dfr_ramp_props_i (.clk_sys, .rst, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .freq_setpoint, .running, .regen_extend);

// ### tb/dfr_stage_model.sv
`timescale 1ns/10ps
// ****************
// power stage and analog source
// ****************
module dfr_stage_model (
    input wire logic        clk_sys,
    input wire logic        regen_cmd,
    input wire logic        src_sel,
    input wire logic [11:0] code,
    output logic            regen_detect,
    output logic            analog_src_current,
    output logic [11:0]     analog_volt_code,
    output logic [11:0]     analog_curr_code
);
    // unselected input wanders so a wrong pick never matches by luck
    logic [11:0] junk_q = 12'hA5A;
    always @(posedge clk_sys) junk_q <= junk_q + 12'h5A5;
    assign regen_detect = regen_cmd;
    assign analog_src_current = src_sel;
    assign analog_volt_code = src_sel ? junk_q : code;
    assign analog_curr_code = src_sel ? code : junk_q;
endmodule

// ### tb/dfr_ramp_bench.sv
`timescale 1ns/10ps
// ****************
// ramp bench
// ****************
module dfr_ramp_bench;
    localparam int T = 10;
    logic        clk_sys, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, run_request;
    logic        keypad_fitted, floor_switch_on, analog_src_current, regen_detect, running, regen_extend;
    logic        regen_cmd, src_sel;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [11:0] analog_volt_code, analog_curr_code, code;
    logic [23:0] freq_setpoint, f0;
    logic [7:0]  ad [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    logic [7:0]  ex [6] = '{8'h00, 8'h1E, 8'h3C, 8'h08, 8'h08, 8'h00};
    int          num_errors = 0, num_checks = 0, seed = 32'haff6, n;
    dfr_ramp #(.TICK_CYCLES(T)) dfr_ramp_i (.*);
    dfr_stage_model dfr_stage_model_i (.*);
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        #2000000 num_errors++;
        end_of_test;
    end
    function automatic logic [23:0] hz(input int h);
        return 24'(h << 16);
    endfunction
    function automatic int ana(input int c);
        return 60 * c / 4096;
    endfunction
    task automatic chk(input logic c, input string m);
        num_checks++;
        if (c !== 1'b1) begin
            num_errors++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdw(input logic [7:0] a);
        @(posedge clk_sys);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        {rd, rs} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask
    task automatic wt(input logic [23:0] f, input string m);
        for (n = 0; freq_setpoint !== f && n < 1000 * T + 300; n++) @(negedge clk_sys);
        chk(n < 1000 * T + 300, m);
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        {rst, keypad_fitted, s_axi_wstrb} = 6'h3F;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
        {s_axi_arvalid, s_axi_rready, run_request, floor_switch_on, regen_cmd, src_sel, code} = '0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rdw(ad[i]);
            chk(rd === {24'h0, ex[i]} && rs === dfr_pkg::RESP_OKAY, "reset value");
        end
        rdw(8'h20);
        chk(rs === dfr_pkg::RESP_SLVERR, "unmapped read");
        wr(dfr_pkg::REG_FLOOR, 32'hC8);
        rdw(dfr_pkg::REG_FLOOR);
        chk(rd === 32'h78, "floor limit");
        wr(dfr_pkg::REG_FLOOR, 32'h1E);
        wr(dfr_pkg::REG_RAMP_UP, 32'h1);
        wr(dfr_pkg::REG_RAMP_DN, 32'h1);
        $display("test registers done");
        run_request <= 1'b1;
        wt(hz(30), "fast start");
        wt(hz(60), "slow start");
        run_request <= 1'b0;
        regen_cmd <= 1'b1;
        repeat (3 * T) @(negedge clk_sys);
        f0 = freq_setpoint;
        repeat (20 * T) @(negedge clk_sys);
        chk(freq_setpoint === f0 && regen_extend === 1'b1, "regen hold");
        regen_cmd <= 1'b0;
        wt(hz(30), "slow stop");
        wt(24'h0, "fast stop");
        repeat (4) @(negedge clk_sys);
        chk(running === 1'b0, "stopped");
        $display("test ramps done");
        wr(dfr_pkg::REG_FLOOR, 32'h0);
        wr(dfr_pkg::REG_PROFILE, 32'h1);
        src_sel <= 1'($random(seed));
        code <= 12'($random(seed));
        run_request <= 1'b1;
        repeat (1000 * T + 300) @(negedge clk_sys);
        chk(freq_setpoint[23:16] - ana(code) + 1 <= 2, "analog speed");
        wr(dfr_pkg::REG_CTRL, 32'h1);
        wt(hz(60), "hand mode");
        wr(dfr_pkg::REG_CTRL, 32'h0);
        wr(dfr_pkg::REG_FLOOR, 32'h1E);
        code <= 12'h100;
        wt(hz(30), "analog floor");
        {keypad_fitted, floor_switch_on} <= 2'h1;
        repeat (100 * T) @(negedge clk_sys);
        chk(freq_setpoint[23:16] === 8'h1E && freq_setpoint > hz(30), "basic unit ramp");
        $display("test analog done");
        end_of_test;
    end
endmodule
